// ### pkg/msw_pkg.sv
// shared constants and types for the memory-select switch control block
package msw_pkg;
   // time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 14;
   // times counted in 1 ms ticks
   localparam logic [13:0] DEBOUNCE_MS = 14'h0014;
   localparam logic [13:0] REL_SHORT_MS = 14'h05DC;
   localparam logic [13:0] REL_MID_MS = 14'h0DAC;
   localparam logic [13:0] REL_LONG_MS = 14'h157C;
   localparam logic [13:0] INDICATE_MS = 14'h00C8;
   localparam logic [13:0] POR_UNIT_MS = 14'h03E8;
   // release delay selector codes
   localparam logic [1:0] REL_OFF = 2'h0;
   localparam logic [1:0] REL_SHORT = 2'h1;
   localparam logic [1:0] REL_MID = 2'h2;
   // memories
   localparam logic [2:0] MAX_MEMORIES = 3'h6;
   localparam logic [2:0] MEM_A = 3'h0;
   localparam logic [2:0] MEM_B = 3'h1;
   // switch inputs
   localparam int NUM_INPUTS = 4;
   localparam int IN_SEL1 = 0;
   localparam int IN_SEL2 = 1;
   localparam int IN_UP = 2;
   localparam int IN_DOWN = 3;
   // gain steps
   localparam logic [7:0] VOL_STEP = 8'h08;
   localparam logic [7:0] VOL_MAX = 8'hFF;
   localparam logic [7:0] FADE_STEP = 8'h20;
   localparam logic [7:0] FADE_FULL = 8'hFF;
   // register map (word indices)
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_VALID = 4'h1;
   localparam logic [3:0] ADDR_FIXVOL = 4'h2;
   localparam logic [3:0] ADDR_PORDLY = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_VOLUME = 4'h5;
   // control register fields
   localparam int CTRL_STATIC_BIT = 0;
   localparam int CTRL_DEDICATE_BIT = 1;
   localparam int CTRL_POL_LSB = 2;
   localparam int CTRL_REL_LSB = 6;
   localparam int CTRL_VMODE_LSB = 8;
   localparam int CTRL_LOG_BIT = 10;
   localparam int CTRL_ROCKER_BIT = 11;
   localparam int CTRL_IND_BIT = 12;
   localparam logic [15:0] CTRL_RESET = 16'h1000;
   localparam logic [2:0] VALID_RESET = 3'h1;
   localparam logic [7:0] FIXVOL_RESET = 8'h80;
   localparam logic [3:0] POR_RESET = 4'h0;
   localparam logic [3:0] POR_MAX_SEL = 4'hB;
   // volume sources
   typedef enum logic [1:0] {VOL_FIXED, VOL_ANALOG, VOL_DIGITAL} vol_mode_t;
   // memory change sequencer
   typedef enum {FADE_IDLE, FADE_OUT, FADE_INDICATE, FADE_SWITCH, FADE_IN}
      fade_state_t;
endpackage

// ### verilog/memory_select_switch_control.sv
// memory-select and volume switch control with fader sequencing
// Contract
// - up to six memories; memory A always valid
// - switch-type and dedicate-last settings govern switch behaviour
// - four modes: momentary, momentary plus jump, binary static, static jump
// - per-input polarity: pull-down closed reads high, pull-up closed low
// - mode 1 starts in A, steps each press, wraps to A
// - mode 1 when momentary and dedicate disabled
// - closing second input jumps to the designated last memory
// - static dedicated second input holds last memory 1.5/3.5/5.5 s or off
// - volume up closure raises gain, volume down closure lowers it
// - one volume source active; rocker may also select memories
// - volume fixed by configuration or adjusted at run time
// - analog position mapped by log or linear taper
// - memory change: fade out, indicator, switch, fade in
// - momentary presses ignored during power-on delay
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module memory_select_switch_control #(
   parameter int TickCycles = msw_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // switch pins
   input wire logic firstSelectInput,
   input wire logic secondSelectInput,
   input wire logic volumeUpInput,
   input wire logic volumeDownInput,
   // analog volume position from the converter
   input wire logic [7:0] analogPos,
   // register port
   input wire logic [msw_pkg::ADDR_W-1:0] regAddr,
   input wire logic [msw_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [msw_pkg::DATA_W-1:0] regRdData_q,
   // audio path controls
   output logic [2:0] memSel_q,
   output logic [7:0] volGain_q,
   output logic [7:0] fadeGain_q,
   output logic indicatorOn_q
);
   localparam int TW = $clog2(TickCycles + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TickCycles - 1);
   localparam int CW = msw_pkg::CNT_W;

   logic [TW-1:0] tickCnt_q, tickCnt_d;
   logic tick;
   logic [15:0] ctrl_q, ctrl_d;
   logic [2:0] validCnt_q, validCnt_d;
   logic [7:0] fixVol_q, fixVol_d;
   logic [3:0] porSel_q, porSel_d;
   logic [15:0] rdData_d;
   logic [msw_pkg::NUM_INPUTS-1:0] rawIn, closed, press;
   logic swStatic, dedicate, rocker, indEn, logTaper;
   logic [1:0] relSel, vmodeRaw;
   logic [2:0] lastMem;
   logic porBusy_q, porBusy_d;
   logic [CW-1:0] porCnt_q, porCnt_d;

   // millisecond tick shared by every timer
   always_comb begin
      tickCnt_d = (tickCnt_q == TICK_LAST) ? '0 : tickCnt_q + 1'b1;
   end
   assign tick = (tickCnt_q == TICK_LAST);
   always_ff @(posedge ref_clk) begin
      if (srst) tickCnt_q <= '0;
      else tickCnt_q <= tickCnt_d;
   end

   // configuration fields
   assign swStatic = ctrl_q[msw_pkg::CTRL_STATIC_BIT];
   assign dedicate = ctrl_q[msw_pkg::CTRL_DEDICATE_BIT];
   assign relSel = ctrl_q[msw_pkg::CTRL_REL_LSB +: 2];
   assign vmodeRaw = ctrl_q[msw_pkg::CTRL_VMODE_LSB +: 2];
   assign logTaper = ctrl_q[msw_pkg::CTRL_LOG_BIT];
   assign rocker = ctrl_q[msw_pkg::CTRL_ROCKER_BIT];
   assign indEn = ctrl_q[msw_pkg::CTRL_IND_BIT];
   assign lastMem = validCnt_q - 3'h1;
   assign rawIn = {volumeDownInput, volumeUpInput, secondSelectInput,
                   firstSelectInput};

   genvar gi;
   for (gi = 0; gi < msw_pkg::NUM_INPUTS; gi++) begin : g_in
      logic meta_q, sync_q, lvl_q, lvl_d, pulse_q, pulse_d, now;
      logic [CW-1:0] cnt_q, cnt_d;
      // polarity: pull-up means closed reads low
      assign now = sync_q ^ ctrl_q[msw_pkg::CTRL_POL_LSB + gi];
      // a level must hold for the whole debounce window before it counts
      always_comb begin
         lvl_d = lvl_q;
         cnt_d = cnt_q;
         if (now == lvl_q) begin
            cnt_d = '0;
         end else if (tick) begin
            if (cnt_q == msw_pkg::DEBOUNCE_MS - 1'b1) begin
               lvl_d = now;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         pulse_d = lvl_d & ~lvl_q;
      end
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            lvl_q <= 1'b0;
            pulse_q <= 1'b0;
            cnt_q <= '0;
         end else begin
            meta_q <= rawIn[gi];
            sync_q <= meta_q;
            lvl_q <= lvl_d;
            pulse_q <= pulse_d;
            cnt_q <= cnt_d;
         end
      end
      assign closed[gi] = lvl_q;
      assign press[gi] = pulse_q;
   end

   // power-on delay counted in seconds of ticks
   always_comb begin
      porBusy_d = porBusy_q;
      porCnt_d = porCnt_q;
      if (porBusy_q && tick) begin
         if (porCnt_q >= CW'(porSel_q * msw_pkg::POR_UNIT_MS)) begin
            porBusy_d = 1'b0;
         end else begin
            porCnt_d = porCnt_q + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         porBusy_q <= 1'b1;
         porCnt_q <= '0;
      end else begin
         porBusy_q <= porBusy_d;
         porCnt_q <= porCnt_d;
      end
   end

   // telecoil hold on the dedicated second input
   logic tcHold_q, tcHold_d;
   logic [CW-1:0] relCnt_q, relCnt_d, relLimit;
   always_comb begin
      case (relSel)
         msw_pkg::REL_SHORT: relLimit = msw_pkg::REL_SHORT_MS;
         msw_pkg::REL_MID: relLimit = msw_pkg::REL_MID_MS;
         default: relLimit = msw_pkg::REL_LONG_MS;
      endcase
      tcHold_d = tcHold_q;
      relCnt_d = '0;
      // release debounce after the switch opens
      if (!dedicate) begin
         tcHold_d = 1'b0;
      end else if (closed[msw_pkg::IN_SEL2]) begin
         tcHold_d = 1'b1;
      end else if (tcHold_q) begin
         if (relSel == msw_pkg::REL_OFF) begin
            tcHold_d = 1'b0;
         end else begin
            relCnt_d = relCnt_q + (tick ? 1'b1 : 1'b0);
            if (relCnt_q >= relLimit) tcHold_d = 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tcHold_q <= 1'b0;
         relCnt_q <= '0;
      end else begin
         tcHold_q <= tcHold_d;
         relCnt_q <= relCnt_d;
      end
   end

   // requested memory per switch mode
   logic [2:0] wantMem_q, wantMem_d, savedMem_q, savedMem_d, binIdx;
   logic stepFwd, stepBack;
   always_comb begin
      wantMem_d = wantMem_q;
      savedMem_d = savedMem_q;
      // a rocker on the volume pins may also step memories
      stepFwd = (rocker ? press[msw_pkg::IN_UP] : press[msw_pkg::IN_SEL1])
                & ~porBusy_q;
      stepBack = rocker & press[msw_pkg::IN_DOWN] & ~porBusy_q;
      binIdx = {1'b0, closed[msw_pkg::IN_SEL2], closed[msw_pkg::IN_SEL1]};
      // settings pick the mode; four modes
      case ({swStatic, dedicate})
         // momentary and no dedicate gives mode 1
         2'b00: begin
            if (stepFwd) begin
               wantMem_d = (wantMem_q >= lastMem) ? msw_pkg::MEM_A
                           : wantMem_q + 3'h1;
            end else if (stepBack) begin
               wantMem_d = (wantMem_q == msw_pkg::MEM_A) ? lastMem
                           : wantMem_q - 3'h1;
            end
         end
         2'b01: begin
            // jump to last memory, restore on release
            if (tcHold_d) begin
               if (!tcHold_q) savedMem_d = wantMem_q;
               wantMem_d = lastMem;
            end else if (tcHold_q) begin
               wantMem_d = savedMem_q;
            end else if (stepFwd) begin
               wantMem_d = (wantMem_q + 3'h1 >= lastMem) ? msw_pkg::MEM_A
                           : wantMem_q + 3'h1;
            end
         end
         2'b10: begin
            wantMem_d = (binIdx < validCnt_q) ? binIdx : msw_pkg::MEM_A;
         end
         default: begin
            if (tcHold_d) wantMem_d = lastMem;
            else if (closed[msw_pkg::IN_SEL1] && validCnt_q > 3'h1)
               wantMem_d = msw_pkg::MEM_B;
            else wantMem_d = msw_pkg::MEM_A;
         end
      endcase
      // a shrunken memory count pulls a stale request back to A
      if (wantMem_q > lastMem) wantMem_d = msw_pkg::MEM_A;
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wantMem_q <= msw_pkg::MEM_A;
         savedMem_q <= msw_pkg::MEM_A;
      end else begin
         wantMem_q <= wantMem_d;
         savedMem_q <= savedMem_d;
      end
   end

   // fade out, indicator, switch, fade in
   msw_pkg::fade_state_t state_q, state_d;
   logic [2:0] memSel_d;
   logic [7:0] fade_d;
   logic [CW-1:0] indCnt_q, indCnt_d;
   always_comb begin
      state_d = state_q;
      memSel_d = memSel_q;
      fade_d = fadeGain_q;
      indCnt_d = '0;
      case (state_q)
         msw_pkg::FADE_IDLE: begin
            if (wantMem_q != memSel_q) state_d = msw_pkg::FADE_OUT;
         end
         msw_pkg::FADE_OUT: begin
            if (tick) begin
               fade_d = (fadeGain_q > msw_pkg::FADE_STEP)
                        ? fadeGain_q - msw_pkg::FADE_STEP : 8'h00;
            end
            if (fadeGain_q == 8'h00) begin
               state_d = indEn ? msw_pkg::FADE_INDICATE
                         : msw_pkg::FADE_SWITCH;
            end
         end
         msw_pkg::FADE_INDICATE: begin
            indCnt_d = indCnt_q + (tick ? 1'b1 : 1'b0);
            if (indCnt_q >= msw_pkg::INDICATE_MS) begin
               state_d = msw_pkg::FADE_SWITCH;
            end
         end
         msw_pkg::FADE_SWITCH: begin
            memSel_d = (wantMem_q > lastMem) ? msw_pkg::MEM_A : wantMem_q;
            state_d = msw_pkg::FADE_IN;
         end
         msw_pkg::FADE_IN: begin
            if (tick) begin
               fade_d = (fadeGain_q < msw_pkg::FADE_FULL - msw_pkg::FADE_STEP)
                        ? fadeGain_q + msw_pkg::FADE_STEP : msw_pkg::FADE_FULL;
            end
            if (fadeGain_q == msw_pkg::FADE_FULL) state_d = msw_pkg::FADE_IDLE;
         end
         default: state_d = msw_pkg::FADE_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= msw_pkg::FADE_IDLE;
         memSel_q <= msw_pkg::MEM_A;
         fadeGain_q <= msw_pkg::FADE_FULL;
         indCnt_q <= '0;
         indicatorOn_q <= 1'b0;
      end else begin
         state_q <= state_d;
         memSel_q <= memSel_d;
         fadeGain_q <= fade_d;
         indCnt_q <= indCnt_d;
         indicatorOn_q <= (state_d == msw_pkg::FADE_INDICATE);
      end
   end

   // volume source selection and digital stepping
   logic [7:0] digVol_q, digVol_d, volGain_d;
   logic [15:0] posSq;
   assign posSq = 16'(analogPos) * 16'(analogPos);
   always_comb begin
      digVol_d = digVol_q;
      if (vmodeRaw == msw_pkg::VOL_DIGITAL && !rocker && !porBusy_q) begin
         if (press[msw_pkg::IN_UP]) begin
            digVol_d = (digVol_q > msw_pkg::VOL_MAX - msw_pkg::VOL_STEP)
                       ? msw_pkg::VOL_MAX : digVol_q + msw_pkg::VOL_STEP;
         end else if (press[msw_pkg::IN_DOWN]) begin
            digVol_d = (digVol_q < msw_pkg::VOL_STEP) ? 8'h00
                       : digVol_q - msw_pkg::VOL_STEP;
         end
      end
      // exactly one source drives the gain; fixed or live
      case (vmodeRaw)
         msw_pkg::VOL_DIGITAL: volGain_d = digVol_q;
         // squared position approximates a log taper
         msw_pkg::VOL_ANALOG: volGain_d = logTaper ? posSq[15:8] : analogPos;
         default: volGain_d = fixVol_q;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         digVol_q <= msw_pkg::FIXVOL_RESET;
         volGain_q <= msw_pkg::FIXVOL_RESET;
      end else begin
         digVol_q <= digVol_d;
         volGain_q <= volGain_d;
      end
   end

   // register writes and one-cycle read data; unmapped reads return zero
   always_comb begin
      ctrl_d = ctrl_q;
      validCnt_d = validCnt_q;
      fixVol_d = fixVol_q;
      porSel_d = porSel_q;
      rdData_d = '0;
      if (regWrEn) begin
         case (regAddr)
            msw_pkg::ADDR_CTRL: ctrl_d = {3'h0, regWrData[12:0]};
            // count is clamped so memory A always stays valid
            msw_pkg::ADDR_VALID: begin
               if (regWrData[2:0] == 3'h0) validCnt_d = 3'h1;
               else if (regWrData[2:0] > msw_pkg::MAX_MEMORIES)
                  validCnt_d = msw_pkg::MAX_MEMORIES;
               else validCnt_d = regWrData[2:0];
            end
            msw_pkg::ADDR_FIXVOL: fixVol_d = regWrData[7:0];
            msw_pkg::ADDR_PORDLY: begin
               porSel_d = (regWrData[3:0] > msw_pkg::POR_MAX_SEL)
                          ? msw_pkg::POR_MAX_SEL : regWrData[3:0];
            end
            default: ;
         endcase
      end
      if (regRdEn) begin
         case (regAddr)
            msw_pkg::ADDR_CTRL: rdData_d = ctrl_q;
            msw_pkg::ADDR_VALID: rdData_d = {13'h0, validCnt_q};
            msw_pkg::ADDR_FIXVOL: rdData_d = {8'h00, fixVol_q};
            msw_pkg::ADDR_PORDLY: rdData_d = {12'h000, porSel_q};
            msw_pkg::ADDR_STATUS: rdData_d = {3'h0, closed, indicatorOn_q,
               tcHold_q, porBusy_q, wantMem_q, memSel_q};
            msw_pkg::ADDR_VOLUME: rdData_d = {fadeGain_q, volGain_q};
            default: rdData_d = '0;
         endcase
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_q <= msw_pkg::CTRL_RESET;
         validCnt_q <= msw_pkg::VALID_RESET;
         fixVol_q <= msw_pkg::FIXVOL_RESET;
         porSel_q <= msw_pkg::POR_RESET;
         regRdData_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         validCnt_q <= validCnt_d;
         fixVol_q <= fixVol_d;
         porSel_q <= porSel_d;
         regRdData_q <= rdData_d;
      end
   end

   // checks on the sequencing
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic modeOne, modeTwo;
   assign modeOne = !swStatic && !dedicate;
   assign modeTwo = !swStatic && dedicate;

   property p_switchValid;
      state_q == msw_pkg::FADE_SWITCH |=> memSel_q <= $past(lastMem);
   endproperty
   a_switchValid: assert property (p_switchValid)
      else $error("switched to a memory past the last valid one");
   property p_modeOneStep;
      (modeOne && !rocker && press[msw_pkg::IN_SEL1] && !porBusy_q
       && wantMem_q <= lastMem) |=> wantMem_q ==
         (($past(wantMem_q) >= $past(lastMem)) ? 3'h0
          : 3'($past(wantMem_q) + 3'h1));
   endproperty
   a_modeOneStep: assert property (p_modeOneStep)
      else $error("mode one press did not step or wrap");
   property p_jump;
      (modeTwo && tcHold_d && wantMem_q <= lastMem)
         |=> wantMem_q == $past(lastMem);
   endproperty
   a_jump: assert property (p_jump)
      else $error("held second input did not request last memory");
   property p_hold;
      (dedicate && closed[msw_pkg::IN_SEL2]) |=> tcHold_q;
   endproperty
   a_hold: assert property (p_hold)
      else $error("telecoil hold dropped while switch closed");
   property p_volUp;
      (vmodeRaw == msw_pkg::VOL_DIGITAL && !rocker && !porBusy_q
       && press[msw_pkg::IN_UP] && digVol_q < 8'hF0)
         |=> digVol_q == 8'($past(digVol_q) + msw_pkg::VOL_STEP) ##1
             volGain_q == $past(digVol_q, 1);
   endproperty
   a_volUp: assert property (p_volUp)
      else $error("volume up press did not raise gain by one step");
   property p_volFixed;
      (vmodeRaw == msw_pkg::VOL_FIXED) |=> volGain_q == $past(fixVol_q);
   endproperty
   a_volFixed: assert property (p_volFixed)
      else $error("fixed volume not applied");
   property p_onlyAtSwitch;
      (memSel_q != $past(memSel_q)) |-> $past(state_q) == msw_pkg::FADE_SWITCH;
   endproperty
   a_onlyAtSwitch: assert property (p_onlyAtSwitch)
      else $error("memory changed outside the switch step");
   property p_silentSwitch;
      state_q == msw_pkg::FADE_SWITCH |-> fadeGain_q == 8'h00
         ##1 state_q == msw_pkg::FADE_IN;
   endproperty
   a_silentSwitch: assert property (p_silentSwitch)
      else $error("memory switched while audio not faded out");
   property p_porIgnore;
      (porBusy_q && modeOne && wantMem_q <= lastMem) |=> $stable(wantMem_q);
   endproperty
   a_porIgnore: assert property (p_porIgnore)
      else $error("press acted on during power-on delay");
   property p_onePulse;
      press[msw_pkg::IN_SEL1] |=> !press[msw_pkg::IN_SEL1];
   endproperty
   a_onePulse: assert property (p_onePulse)
      else $error("press pulse longer than one cycle");

   c_wrap: cover property (modeOne && state_q == msw_pkg::FADE_SWITCH
      && wantMem_q == msw_pkg::MEM_A && memSel_q == lastMem);
   c_jump: cover property (modeTwo && $rose(tcHold_q));
   c_release: cover property (modeTwo && $fell(tcHold_q));
   c_indicator: cover property ($rose(indicatorOn_q));
endmodule

// ### verification/switch_bank.sv
// behavioural bank of user switches wired to the four switch pins
`timescale 1ns/1ps
module switch_bank (
   // clock used only to make contact chatter
   input wire logic ref_clk,
   // contact state, wiring and bounce request per switch
   input wire logic [3:0] closed,
   input wire logic [3:0] pullUp,
   input wire logic [3:0] chatter,
   // pin levels seen by the device
   output logic [3:0] pins
);
   logic flip = 1'b0;
   // chatter flips every cycle so a bouncing contact never looks settled
   always @(posedge ref_clk) begin
      flip <= ~flip;
   end
   // closed reads high on pull-down wiring, low on pull-up wiring
   assign pins = (closed ^ pullUp) ^ (chatter & {4{flip}});
endmodule

// ### verification/memory_select_switch_control_bench.sv
// self-checking bench for the memory-select switch control block
`timescale 1ns/1ps
module memory_select_switch_control_bench;
   localparam int T = 10;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] closed = 4'h0;
   logic [3:0] pullUp = 4'h0;
   logic [3:0] chatter = 4'h0;
   logic [3:0] pins;
   logic [7:0] analogPos = 8'h00;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [15:0] regRdData_q;
   logic [2:0] memSel_q;
   logic [7:0] volGain_q;
   logic [7:0] fadeGain_q;
   logic indicatorOn_q;
   logic sawInd = 1'b0;
   logic sawMute = 1'b0;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 32'h0858a099;
   int n;
   int k;
   switch_bank i_switch_bank (.ref_clk(ref_clk), .closed(closed),
      .pullUp(pullUp), .chatter(chatter), .pins(pins));
   memory_select_switch_control #(.TickCycles(T))
      i_memory_select_switch_control (.ref_clk(ref_clk), .srst(srst),
      .firstSelectInput(pins[msw_pkg::IN_SEL1]),
      .secondSelectInput(pins[msw_pkg::IN_SEL2]),
      .volumeUpInput(pins[msw_pkg::IN_UP]),
      .volumeDownInput(pins[msw_pkg::IN_DOWN]), .analogPos(analogPos),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData_q(regRdData_q), .memSel_q(memSel_q),
      .volGain_q(volGain_q), .fadeGain_q(fadeGain_q),
      .indicatorOn_q(indicatorOn_q));
   always #5 ref_clk = ~ref_clk;
   // watch the fader and cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (indicatorOn_q === 1'b1) sawInd <= 1'b1;
      if (fadeGain_q === 8'h00) sawMute <= 1'b1;
      if (cycles == 90000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // pin wiring follows the polarity written, so no false edge is debounced
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      if (a == msw_pkg::ADDR_CTRL) pullUp <= d[5:2];
      @(posedge ref_clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
         input string what);
      @(posedge ref_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1;
      chk(what, exp, regRdData_q);
   endtask
   task automatic ticks(input int t);
      repeat (t * T) @(posedge ref_clk);
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      srst <= 1'b1;
      pullUp <= 4'h0;
      closed <= 4'h0;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   // wait for the fader to finish on the expected memory
   task automatic memis(input logic [2:0] exp, input string what);
      for (k = 0; k < 8000 && !(memSel_q === exp && fadeGain_q === 8'hFF);
            k++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(what, {13'h0, exp}, {13'h0, memSel_q});
   endtask
   // a bouncing close held well past the debounce time, then released
   task automatic press(input int idx);
      @(posedge ref_clk);
      closed[idx] <= 1'b1;
      chatter[idx] <= 1'b1;
      ticks(3);
      chatter[idx] <= 1'b0;
      ticks(30);
      closed[idx] <= 1'b0;
      ticks(30);
      for (k = 0; k < 4000 && fadeGain_q !== 8'hFF; k++) begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic setsw(input int idx, input logic v);
      @(posedge ref_clk);
      closed[idx] <= v;
   endtask
   initial begin
      do_reset();
      rdchk(msw_pkg::ADDR_CTRL, 16'h1000, "ctrl reset");
      rdchk(msw_pkg::ADDR_VALID, 16'h0001, "valid reset");
      wr(msw_pkg::ADDR_VALID, 16'h0000);
      rdchk(msw_pkg::ADDR_VALID, 16'h0001, "valid zero");
      wr(msw_pkg::ADDR_VALID, 16'h0007);
      rdchk(msw_pkg::ADDR_VALID, 16'h0006, "valid max");
      rdchk(4'hF, 16'h0000, "unmapped read");
      chk("mem reset", 16'h0000, {13'h0, memSel_q});
      $display("test registers done");
      // random count and wiring; indicator left enabled here and in the power-on delay test
      n = 2 + $unsigned($random(seed)) % 5;
      wr(msw_pkg::ADDR_VALID, 16'(n));
      wr(msw_pkg::ADDR_CTRL, 16'h1000 | (16'($random(seed)) & 16'h003C));
      for (int p = 1; p <= n + 1; p++) begin
         press(msw_pkg::IN_SEL1);
         chk("mode1 mem", 16'(p % n), {13'h0, memSel_q});
      end
      chk("indicator", 16'h0001, {15'h0, sawInd});
      chk("faded out", 16'h0001, {15'h0, sawMute});
      setsw(0, 1'b1);
      ticks(5);
      setsw(0, 1'b0);
      ticks(40);
      chk("short glitch", 16'h0001, {13'h0, memSel_q});
      $display("test mode1 done");
      do_reset();
      wr(msw_pkg::ADDR_VALID, 16'h0004);
      wr(msw_pkg::ADDR_CTRL, 16'h0042 | (16'($random(seed)) & 16'h003C));
      press(msw_pkg::IN_SEL1);
      memis(3'h1, "mode2 step");
      setsw(1, 1'b1);
      memis(3'h3, "telecoil jump");
      setsw(1, 1'b0);
      ticks(1000);
      chk("hold after open", 16'h0003, {13'h0, memSel_q});
      memis(3'h1, "hold release");
      $display("test mode2 done");
      do_reset();
      wr(msw_pkg::ADDR_VALID, 16'h0004);
      wr(msw_pkg::ADDR_CTRL, 16'h0001);
      setsw(0, 1'b1);
      memis(3'h1, "binary 01");
      setsw(1, 1'b1);
      memis(3'h3, "binary 11");
      setsw(0, 1'b0);
      memis(3'h2, "binary 10");
      wr(msw_pkg::ADDR_CTRL, 16'h0003);
      memis(3'h3, "mode4 last");
      setsw(1, 1'b0);
      memis(3'h0, "mode4 open");
      $display("test static modes done");
      do_reset();
      // rocker on the volume pins steps memories, volume left alone
      wr(msw_pkg::ADDR_VALID, 16'h0003);
      wr(msw_pkg::ADDR_CTRL, 16'h0A00);
      press(msw_pkg::IN_UP);
      chk("rocker up", 16'h0001, {13'h0, memSel_q});
      press(msw_pkg::IN_DOWN);
      press(msw_pkg::IN_DOWN);
      chk("rocker down", 16'h0002, {13'h0, memSel_q});
      chk("rocker vol", 16'h0080, {8'h0, volGain_q});
      wr(msw_pkg::ADDR_CTRL, 16'h0200);
      press(msw_pkg::IN_UP);
      chk("vol up", 16'h0088, {8'h0, volGain_q});
      press(msw_pkg::IN_DOWN);
      press(msw_pkg::IN_DOWN);
      chk("vol down", 16'h0078, {8'h0, volGain_q});
      @(posedge ref_clk);
      analogPos <= 8'($random(seed));
      wr(msw_pkg::ADDR_CTRL, 16'h0100);
      ticks(1);
      chk("linear taper", {8'h0, analogPos}, {8'h0, volGain_q});
      wr(msw_pkg::ADDR_CTRL, 16'h0500);
      ticks(1);
      chk("log taper", ({8'h0, analogPos} * {8'h0, analogPos}) >> 8,
         {8'h0, volGain_q});
      wr(msw_pkg::ADDR_FIXVOL, 16'h0033);
      wr(msw_pkg::ADDR_CTRL, 16'h0000);
      ticks(1);
      chk("fixed volume", 16'h0033, {8'h0, volGain_q});
      $display("test volume done");
      // one second of power-on delay: a press inside it is dropped
      do_reset();
      wr(msw_pkg::ADDR_PORDLY, 16'h0001);
      wr(msw_pkg::ADDR_VALID, 16'h0002);
      press(msw_pkg::IN_SEL1);
      chk("por ignore", 16'h0000, {13'h0, memSel_q});
      ticks(1000);
      press(msw_pkg::IN_SEL1);
      chk("after por", 16'h0001, {13'h0, memSel_q});
      $display("test power-on delay done");
      give_verdict();
   end
endmodule
